// file: hw/bbfc_params.svh
`ifndef BBFC_PARAMS_SVH
`define BBFC_PARAMS_SVH
// software-facing register offsets of the controller
`define BBFC_REG_CTRL      4'h0
`define BBFC_REG_ADDR      4'h1
`define BBFC_REG_WDATA     4'h2
`define BBFC_REG_RDATA     4'h3
`define BBFC_REG_STATUS    4'h4
// control register field positions
`define BBFC_CTRL_GO       0
`define BBFC_CTRL_OP_LSB   1
`define BBFC_CTRL_OP_MSB   3
`define BBFC_CTRL_UNLOCK   4
`define BBFC_CTRL_PROG_HI  5
`define BBFC_CTRL_ID_HV    6
`define BBFC_CTRL_RESET    7
// status register field positions
`define BBFC_STAT_BUSY     0
`define BBFC_STAT_DONE     1
`define BBFC_STAT_REFUSED  2
// command bytes
`define BBFC_CMD_ERASE_SET 8'h20
`define BBFC_CMD_WRITE_SET 8'h40
`define BBFC_CMD_CONFIRM   8'hD0
`define BBFC_CMD_READ_ARR  8'hFF
`define BBFC_CMD_IDENTIFY  8'h90
`define BBFC_CMD_READ_STAT 8'h70
`define BBFC_CMD_CLR_STAT  8'h50
// bus timing in ns, clock period 50 ns
`define BBFC_CLK_NS        50
`define BBFC_STROBE_NS     100
`define BBFC_ACCESS_NS     100
`define BBFC_STROBE_CYC    ((`BBFC_STROBE_NS + `BBFC_CLK_NS - 1) / `BBFC_CLK_NS)
`define BBFC_ACCESS_CYC    ((`BBFC_ACCESS_NS + `BBFC_CLK_NS - 1) / `BBFC_CLK_NS)
// array geometry
`define BBFC_ADDR_W        18
`define BBFC_BOOT_TOP_LO   18'h3C000
`define BBFC_BOOT_BOT_HI   18'h03FFF
`endif

// file: hw/bbfc_pkg.sv
package bbfc_pkg;
	typedef enum logic [2:0] {
		BBFC_OP_READ,
		BBFC_OP_CMD,
		BBFC_OP_WRITE,
		BBFC_OP_ERASE,
		BBFC_OP_ID
	} bbfc_op_e;
	typedef enum {
		BBFC_IDLE,
		BBFC_SETUP,
		BBFC_GAP,
		BBFC_SECOND,
		BBFC_READ,
		BBFC_DONE
	} bbfc_state_e;
endpackage

// file: hw/bbfc_host.sv
// What this block does
// - host keeps reset pin high except during system reset and while the control reset bit holds the part in reset.
// - array read drives select and output enable low, write strobe high.
// - commands are bytes: erase setup 20H, write setup 10H/40H (this block sends 40H only), read FFH.
// - erase is setup byte then D0H confirm with supply high.
// - byte write is setup command then address/data cycle with supply high.
// - during hardware identify, other address lines held low.
`timescale 1ns/100ps
`include "bbfc_params.svh"
module bbfc_host
	import bbfc_pkg::*;
#(
	parameter bit TOP_BOOT = 1'b1
) (
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic [3:0]  reg_addr_i,
	input  wire logic [31:0] reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic      [31:0] reg_rdata_o,
	output logic [17:0]      byte_address_lines_o,
	input  wire logic [7:0]  data_lines_i,
	output logic [7:0]       data_lines_o,
	output logic             data_lines_oe_o,
	output logic             chip_sel_n_o,
	output logic             out_en_n_o,
	output logic             write_strobe_n_o,
	output logic             reset_n_o,
	output logic             boot_unlock_o,
	output logic             program_supply_high_o,
	output logic             identify_voltage_o
);
	localparam int unsigned STB = `BBFC_STROBE_CYC;
	localparam int unsigned ACC = `BBFC_ACCESS_CYC;
	// strobe count starts a cycle before the pins move, the read count with them
	localparam logic [3:0]  STB_LAST = 4'(STB);
	localparam logic [3:0]  ACC_LAST = 4'(ACC - 1);

	logic [7:0]        ctrl_q;
	logic [17:0]       addr_q;
	logic [7:0]        wdata_q;
	logic [7:0]        rdata_q;
	logic              busy_q;
	logic              done_q;
	logic              refused_q;
	bbfc_state_e       state_q;
	bbfc_op_e          op_q;
	logic [3:0]        cnt_q;
	logic [31:0]       rd_q;

	function automatic logic in_boot(input logic [17:0] a, input logic top);
		in_boot = top ? (a >= `BBFC_BOOT_TOP_LO) : (a <= `BBFC_BOOT_BOT_HI);
	endfunction

	wire sel_ctrl  = reg_addr_i == `BBFC_REG_CTRL;
	wire sel_addr  = reg_addr_i == `BBFC_REG_ADDR;
	wire sel_wdata = reg_addr_i == `BBFC_REG_WDATA;
	wire sel_rdata = reg_addr_i == `BBFC_REG_RDATA;
	wire sel_stat  = reg_addr_i == `BBFC_REG_STATUS;

	wire wr_ctrl   = reg_wr_i && sel_ctrl;
	wire wr_addr   = reg_wr_i && sel_addr;
	wire wr_wdata  = reg_wr_i && sel_wdata;
	wire wr_stat   = reg_wr_i && sel_stat;

	wire go        = wr_ctrl && reg_wdata_i[`BBFC_CTRL_GO];
	// a go while the part is held in reset would strobe a dead device
	wire op_start  = state_q == BBFC_IDLE && go && !ctrl_q[`BBFC_CTRL_RESET];
	wire bbfc_op_e new_op = bbfc_op_e'(reg_wdata_i[`BBFC_CTRL_OP_MSB:`BBFC_CTRL_OP_LSB]);
	wire two_cycle = op_q == BBFC_OP_WRITE || op_q == BBFC_OP_ERASE;
	// boot target without unlock would be silently ignored by the part
	wire boot_block = two_cycle && in_boot(addr_q, TOP_BOOT) && !ctrl_q[`BBFC_CTRL_UNLOCK];
	wire cnt_end   = cnt_q == STB_LAST;
	wire acc_end   = cnt_q == ACC_LAST;
	wire op_refuse = state_q == BBFC_SETUP && boot_block;
	wire op_end    = state_q == BBFC_DONE;
	wire rd_take   = state_q == BBFC_READ && acc_end;
	wire [7:0] first_byte = op_q == BBFC_OP_WRITE ? `BBFC_CMD_WRITE_SET :
		op_q == BBFC_OP_ERASE ? `BBFC_CMD_ERASE_SET :
		op_q == BBFC_OP_ID ? `BBFC_CMD_IDENTIFY :
		op_q == BBFC_OP_READ ? `BBFC_CMD_READ_ARR : wdata_q;
	wire [7:0] second_byte = op_q == BBFC_OP_ERASE ? `BBFC_CMD_CONFIRM : wdata_q;
	// hardware identify: only id select bit may be set
	wire [17:0] id_addr = {17'h0, addr_q[0]};
	wire [31:0] ctrl_word  = {24'h0, ctrl_q};
	wire [31:0] addr_word  = {14'h0, addr_q};
	wire [31:0] wdata_word = {24'h0, wdata_q};
	wire [31:0] rdata_word = {24'h0, rdata_q};
	wire [31:0] stat_word  = {29'h0, refused_q, done_q, busy_q};
	// unused indices read as zero
	wire [31:0] rd_mux =
		sel_ctrl  ? ctrl_word :
		sel_addr  ? addr_word :
		sel_wdata ? wdata_word :
		sel_rdata ? rdata_word :
		sel_stat  ? stat_word : 32'h0;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			rd_q <= 32'h0;
		end else begin
			// zero outside its one cycle, so a stale word never shows
			rd_q <= reg_rd_i ? rd_mux : 32'h0;
		end
	end
	assign reg_rdata_o = rd_q;

	// reloading the address mid-operation moves the data cycle too
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			addr_q  <= 18'h0;
			wdata_q <= 8'h0;
		end else begin
			if (wr_addr) begin
				addr_q <= reg_wdata_i[17:0];
			end
			if (wr_wdata) begin
				wdata_q <= reg_wdata_i[7:0];
			end
		end
	end

	// control frozen while busy so pin levels cannot move mid-operation
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			ctrl_q <= 8'h0;
		end else if (wr_ctrl && state_q == BBFC_IDLE) begin
			ctrl_q <= {reg_wdata_i[7:1], 1'b0};
		end
	end

	// pin levels follow control one cycle late; written with go, they move as the first strobe falls
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			reset_n_o          <= 1'b0;
			boot_unlock_o      <= 1'b0;
			identify_voltage_o <= 1'b0;
		end else begin
			// reset pin high unless held in reset; unlock only when asked
			reset_n_o          <= !ctrl_q[`BBFC_CTRL_RESET];
			// unlock level driven only while boot change requested
			boot_unlock_o      <= ctrl_q[`BBFC_CTRL_UNLOCK] && !ctrl_q[`BBFC_CTRL_RESET];
			identify_voltage_o <= ctrl_q[`BBFC_CTRL_ID_HV];
		end
	end

	// status flags: a set in the same cycle as a clear wins
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			busy_q    <= 1'b0;
			done_q    <= 1'b0;
			refused_q <= 1'b0;
		end else begin
			if (op_start) begin
				busy_q <= 1'b1;
			end else if (op_refuse || op_end) begin
				busy_q <= 1'b0;
			end
			if (op_end) begin
				done_q <= 1'b1;
			end else if (wr_stat) begin
				done_q <= 1'b0;
			end
			if (op_refuse) begin
				refused_q <= 1'b1;
			end else if (op_start) begin
				refused_q <= 1'b0;
			end
		end
	end

	// holds the byte of the last read; write and erase leave it unchanged
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			rdata_q <= 8'h0;
		end else if (rd_take) begin
			rdata_q <= data_lines_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state_q   <= BBFC_IDLE;
			op_q      <= BBFC_OP_READ;
			cnt_q     <= 4'h0;
			byte_address_lines_o  <= 18'h0;
			data_lines_o          <= 8'h0;
			data_lines_oe_o       <= 1'b0;
			chip_sel_n_o          <= 1'b1;
			out_en_n_o            <= 1'b1;
			write_strobe_n_o      <= 1'b1;
			program_supply_high_o <= 1'b0;
		end else begin
			// one pin phase per state; the counter restarts on every entry to SETUP, GAP, SECOND and READ
			case (state_q)
				BBFC_IDLE: begin
					if (op_start) begin
						op_q      <= new_op;
						cnt_q     <= 4'h0;
						state_q   <= BBFC_SETUP;
					end
				end
				BBFC_SETUP: begin
					if (boot_block) begin
						state_q   <= BBFC_IDLE;
					end else if (ctrl_q[`BBFC_CTRL_ID_HV] && op_q == BBFC_OP_ID) begin
						byte_address_lines_o <= id_addr;
						chip_sel_n_o <= 1'b0;
						out_en_n_o   <= 1'b0;
						state_q      <= BBFC_READ;
					end else begin
						// first cycle is a command byte, supply low
						byte_address_lines_o  <= addr_q;
						data_lines_o          <= first_byte;
						data_lines_oe_o       <= 1'b1;
						program_supply_high_o <= 1'b0;
						chip_sel_n_o          <= 1'b0;
						write_strobe_n_o      <= 1'b0;
						cnt_q <= cnt_q + 4'h1;
						if (cnt_end) begin
							// strobe rises first, data held one more cycle
							write_strobe_n_o <= 1'b1;
							chip_sel_n_o     <= 1'b1;
							cnt_q   <= 4'h0;
							state_q <= BBFC_GAP;
						end
					end
				end
				BBFC_GAP: begin
					data_lines_oe_o <= 1'b0;
					cnt_q <= 4'h0;
					if (two_cycle) begin
						// supply raised only for the data or confirm cycle
						program_supply_high_o <= ctrl_q[`BBFC_CTRL_PROG_HI];
						state_q <= BBFC_SECOND;
					end else if (op_q == BBFC_OP_CMD) begin
						state_q <= BBFC_DONE;
					end else begin
						// array or id read after the mode command
						chip_sel_n_o <= 1'b0;
						out_en_n_o   <= 1'b0;
						state_q      <= BBFC_READ;
					end
				end
				BBFC_SECOND: begin
					// confirm or data byte with supply high
					byte_address_lines_o <= addr_q;
					data_lines_o     <= second_byte;
					data_lines_oe_o  <= 1'b1;
					chip_sel_n_o     <= 1'b0;
					write_strobe_n_o <= 1'b0;
					cnt_q <= cnt_q + 4'h1;
					if (cnt_end) begin
						write_strobe_n_o <= 1'b1;
						chip_sel_n_o     <= 1'b1;
						state_q <= BBFC_DONE;
					end
				end
				BBFC_READ: begin
					cnt_q <= cnt_q + 4'h1;
					if (acc_end) begin
						chip_sel_n_o <= 1'b1;
						out_en_n_o   <= 1'b1;
						state_q      <= BBFC_DONE;
					end
				end
				BBFC_DONE: begin
					data_lines_oe_o       <= 1'b0;
					program_supply_high_o <= 1'b0;
					state_q <= BBFC_IDLE;
				end
				default: state_q <= BBFC_IDLE;
			endcase
			// device reset held: pins parked deselected
			if (ctrl_q[`BBFC_CTRL_RESET]) begin
				chip_sel_n_o     <= 1'b1;
				out_en_n_o       <= 1'b1;
				write_strobe_n_o <= 1'b1;
				data_lines_oe_o  <= 1'b0;
			end
		end
	end
endmodule

// file: verif/bbfc_flash_mdl.sv
`timescale 1ns/100ps
module bbfc_flash_mdl #(
	parameter logic [7:0] MFR_ID = 8'hA5, // arbitrary value
	parameter logic [7:0] DEV_ID = 8'h3C  // arbitrary value
) (
	input  wire logic [17:0] addr_i,
	input  wire logic [7:0]  dq_i,
	output logic      [7:0]  dq_o,
	input  wire logic        ce_n_i,
	input  wire logic        oe_n_i,
	input  wire logic        we_n_i,
	input  wire logic        rst_n_i,
	input  wire logic        unl_i,
	input  wire logic        vpp_i,
	input  wire logic        idv_i
);
	logic [7:0]  mem [int];
	logic [17:0] la;
	logic [7:0]  ld;
	logic [7:0]  last = 8'h00;
	logic        arm = 1'b0;
	int          mode = 0;
	int          pend = 0;
	int          p;
	function automatic int blk(input logic [17:0] a);
		return a >= 18'h3C000 ? 4 : a >= 18'h3A000 ? 3 : a >= 18'h38000 ? 2 : int'(a >= 18'h20000);
	endfunction
	// capture only while selected and out of reset
	always @* begin
		if (rst_n_i !== 1'b1) begin
			mode = 0;
			pend = 0;
		end else if (!we_n_i && !ce_n_i) begin
			la = addr_i;
			ld = dq_i;
			arm = 1'b1;
		end
	end
	always @(posedge we_n_i) if (arm && rst_n_i === 1'b1) begin
		arm = 1'b0;
		p = pend;
		pend = 0;
		// boot guard, clear-only write, block erase, done at once
		if (p == 1 && vpp_i) begin
			if (blk(la) < 4 || unl_i) mem[la] = (mem.exists(la) ? mem[la] : 8'hFF) & ld;
			mode = 1;
		end else if (p == 2 && vpp_i && ld == 8'hD0) begin
			if (blk(la) < 4 || unl_i) foreach (mem[k]) if (blk(k) == blk(la)) mem[k] = 8'hFF;
			mode = 1;
		end else case (ld)
			8'h10, 8'h40: pend = 1;
			8'h20: pend = 2;
			8'h90: mode = 2;
			8'h70: mode = 1;
			8'hFF: mode = 0;
			default: ;
		endcase
	end
	// released bus shows inverse; never busy, no faults
	always @(addr_i, ce_n_i, oe_n_i, rst_n_i, idv_i, mode) begin
		if (rst_n_i !== 1'b1 || ce_n_i !== 1'b0 || oe_n_i !== 1'b0) dq_o = ~last;
		else begin
			if (idv_i || mode == 2) dq_o = addr_i[0] ? DEV_ID : MFR_ID;
			else if (mode == 1) dq_o = 8'h80;
			else dq_o = mem.exists(addr_i) ? mem[addr_i] : 8'hFF;
			last = dq_o;
		end
	end
endmodule

// file: verif/bbfc_host_props.sv
`timescale 1ns/100ps
module bbfc_host_chk (
	input wire logic        clk_i,
	input wire logic        sys_rst_i,
	input wire logic [17:0] byte_address_lines_o,
	input wire logic [7:0]  data_lines_o,
	input wire logic        data_lines_oe_o,
	input wire logic        chip_sel_n_o,
	input wire logic        out_en_n_o,
	input wire logic        write_strobe_n_o,
	input wire logic        reset_n_o,
	input wire logic        boot_unlock_o,
	input wire logic        program_supply_high_o,
	input wire logic        identify_voltage_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	sequence s_pulse;
		!write_strobe_n_o [*2] ##1 write_strobe_n_o;
	endsequence
	rd_bus_a: assert property (!out_en_n_o |-> write_strobe_n_o && !data_lines_oe_o && !chip_sel_n_o)
		else $error("read cycle malformed");
	we_sel_a: assert property (!write_strobe_n_o |-> !chip_sel_n_o && out_en_n_o && data_lines_oe_o)
		else $error("strobe without select or drive");
	we_len_a: assert property ($fell(write_strobe_n_o) |-> s_pulse)
		else $error("strobe width wrong");
	we_hold_a: assert property (!write_strobe_n_o && $past(!write_strobe_n_o) |->
		$stable(data_lines_o) && $stable(byte_address_lines_o)) else $error("data moved in strobe");
	unl_rst_a: assert property (boot_unlock_o |-> reset_n_o)
		else $error("unlock while pin low");
	rst_rel_a: assert property ($fell(sys_rst_i) |-> !reset_n_o && chip_sel_n_o ##1 reset_n_o)
		else $error("device reset release wrong");
	id_addr_a: assert property (identify_voltage_o && !out_en_n_o |->
		byte_address_lines_o[17:1] == 17'h00000) else $error("id address not low");
	id_nowr_a: assert property (identify_voltage_o |-> write_strobe_n_o)
		else $error("strobe during id");
	sup_steady_a: assert property ($changed(program_supply_high_o) |-> write_strobe_n_o)
		else $error("supply moved during strobe");
endmodule
bind bbfc_host bbfc_host_chk u_chk (.clk_i, .sys_rst_i, .byte_address_lines_o, .data_lines_o,
	.data_lines_oe_o, .chip_sel_n_o, .out_en_n_o, .write_strobe_n_o, .reset_n_o,
	.boot_unlock_o, .program_supply_high_o, .identify_voltage_o);

// file: verif/bbfc_host_tb.sv
`timescale 1ns/100ps
module bbfc_host_tb;
	logic        clk_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic [3:0]  reg_addr_i = 4'h0;
	logic [31:0] reg_wdata_i = 32'h0;
	logic        reg_wr_i = 1'b0;
	logic        reg_rd_i = 1'b0;
	logic [31:0] reg_rdata_o;
	logic [17:0] adr;
	logic [7:0]  dq_h, dq_m;
	logic        oe, ce_n, oe_n, we_n, rst_n, unl, vpp, idv;
	int          n_fail = 0;
	int          tests_run = 0;
	always #25 clk_i = ~clk_i;
	bbfc_host DUT (.clk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
		.reg_rdata_o, .byte_address_lines_o(adr), .data_lines_i(oe ? dq_h : dq_m),
		.data_lines_o(dq_h), .data_lines_oe_o(oe), .chip_sel_n_o(ce_n), .out_en_n_o(oe_n),
		.write_strobe_n_o(we_n), .reset_n_o(rst_n), .boot_unlock_o(unl),
		.program_supply_high_o(vpp), .identify_voltage_o(idv));
	bbfc_flash_mdl FL (.addr_i(adr), .dq_i(dq_h), .dq_o(dq_m), .ce_n_i(ce_n), .oe_n_i(oe_n),
		.we_n_i(we_n), .rst_n_i(rst_n), .unl_i(unl), .vpp_i(vpp), .idv_i(idv));
	task automatic results;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] v);
		@(posedge clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1 v = reg_rdata_o;
	endtask
	// polls until done or refused; long walks still end well inside the bound
	task automatic op(input logic [17:0] a, input logic [7:0] d, input logic [7:0] c,
		output logic [31:0] s);
		wr(4'h1, {14'h0000, a});
		wr(4'h2, {24'h000000, d});
		wr(4'h0, {24'h000000, c});
		for (int i = 0; i < 40; i++) begin
			rd(4'h4, s);
			if (s[2:1] != 2'b00) break;
		end
		chk("op_end", {31'h0, s[2:1] != 2'b00}, 32'h1);
		wr(4'h4, 32'h0);
	endtask
	task automatic rx(input logic [17:0] a, input logic [7:0] c, input logic [7:0] e);
		logic [31:0] s;
		op(a, 8'h00, c, s);
		rd(4'h3, s);
		chk("rdata", s, {24'h000000, e});
	endtask
	initial begin
		logic [31:0] s;
		repeat (12) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		rd(4'h4, s);
		chk("status", s, 32'h0);
		rx(18'h00100, 8'h01, 8'hFF);
		op(18'h00100, 8'h5A, 8'h25, s);
		rx(18'h00100, 8'h01, 8'h5A);
		op(18'h00100, 8'hF0, 8'h25, s);
		rx(18'h00100, 8'h01, 8'h50);
		op(18'h00200, 8'h00, 8'h05, s);
		rx(18'h00200, 8'h01, 8'hFF);
		op(18'h3C010, 8'h12, 8'h25, s);
		chk("refused", s[2], 1'b1);
		op(18'h3C010, 8'h12, 8'h35, s);
		rx(18'h3C010, 8'h01, 8'h12);
		op(18'h00100, 8'h00, 8'h27, s);
		rx(18'h00100, 8'h01, 8'hFF);
		op(18'h3C010, 8'h20, 8'h03, s);
		chk("cmd_done", s, 32'h00000002);
		rx(18'h3C010, 8'h01, 8'h12);
		rx(18'h00001, 8'h49, 8'h3C);
		rx(18'h00000, 8'h09, 8'hA5);
		rx(18'h00001, 8'h09, 8'h3C);
		rd(4'hF, s);
		chk("unmapped", s, 32'h0);
		results;
	end
	initial begin
		#300000;
		n_fail++;
		results;
	end
endmodule
